// *** inc/lock_cfg.svh ***
// Constants for the section lock checker
`ifndef LOCK_CFG_SVH
`define LOCK_CFG_SVH
`define LOCK_FIELD_OPEN 2'h3
`define LOCK_FIELD_NOWRITE 2'h2
`define LOCK_FIELD_FULL 2'h0
`define LOCK_FIELD_NOREAD 2'h1
`define LOCK_FIELD_RESET 2'h3
`define LOCK_HIGH_POS 1
`define LOCK_LOW_POS 0
`define BOOT_START_DEFAULT 14'h3800
`define VEC_APP_BASE 14'h0000
`endif

// *** inc/lock_pkg.sv ***
// Types shared by the section lock checker
package lock_pkg;
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_LOAD = 2'h1,
      OP_STORE = 2'h3
   } op_type;
   typedef struct packed {
      op_type op;
      logic [13:0] pc;
      logic [13:0] target;
   } access_type;
   typedef struct packed {
      logic granted;
      logic denied;
   } verdict_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CHECK = 2'h1,
      ST_ANSWER = 2'h3
   } state_type;
endpackage : lock_pkg

// *** rtl/lock_field_reg.sv ***
// One 2-bit lock field: software may only program, erase restores
`include "lock_cfg.svh"
module lock_field_reg
   import lock_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [1:0] init_value,
   input wire logic init_load,
   input wire logic [1:0] prog_value,
   input wire logic prog_strobe,
   input wire logic erase,
   output logic [1:0] field
);
   // ==========================================
   // Field storage
   // A bit only moves 1 to 0 except on reset, erase or load; load copies stored bits
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         field <= `LOCK_FIELD_RESET;
      end else if (erase) begin
         field <= `LOCK_FIELD_RESET;
      end else if (init_load) begin
         field <= init_value;
      end else if (prog_strobe) begin
         field <= field & prog_value;
      end
   end
endmodule : lock_field_reg

// *** rtl/section_lock_checker.sv ***
// Flash section lock checker for store and load instructions
// Function
// - App field 11: no limits on stores or loads to application.
// - App field 10: stores into application blocked, loads allowed.
// - App field 00: block app stores and boot-run loads of app.
// - App field 01: app stores allowed, boot-run loads of app blocked.
// - App modes 3,4, vectors in boot: interrupts off in app.
// - Boot field 11: no limits on stores or loads to boot.
// - Boot field 10: stores into boot blocked, loads allowed.
// - Boot field 00: block boot stores and app-run loads of boot.
// - Boot field 01: boot stores allowed, app-run loads of boot blocked.
// - Boot modes 3,4, vectors in app: interrupts off in boot.
// - Lock bit one is unprogrammed, zero programmed; erased is open.
// - Locks set by software or programmer; chip erase or reset clears them, lock load copies the stored values.
// - General write lock does not govern self-program stores.
// - General read/write lock does not govern instruction accesses.
// - Boot-reset fuse moves reset vector to boot section start from the first clock after reset; during reset it is app base.
// - Running code has no path to alter fuses.
`include "lock_cfg.svh"
module section_lock_checker
   import lock_pkg::*;
#(
   parameter int ADDR_W = 14,
   parameter logic [13:0] BOOT_START = `BOOT_START_DEFAULT
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire access_type req,
   input wire logic req_valid,
   output logic req_ready,
   output verdict_type verdict,
   output logic verdict_valid,
   input wire logic [1:0] stored_app_lock,
   input wire logic [1:0] stored_boot_lock,
   input wire logic lock_load,
   input wire logic [1:0] sw_app_lock,
   input wire logic [1:0] sw_boot_lock,
   input wire logic sw_lock_strobe,
   input wire logic ext_lock_strobe,
   input wire logic [1:0] ext_app_lock,
   input wire logic [1:0] ext_boot_lock,
   input wire logic chip_erase,
   input wire logic [1:0] general_lock,
   input wire logic boot_reset_fuse_b,
   input wire logic vectors_in_boot,
   input wire logic [13:0] current_pc,
   input wire logic irq_enable_in,
   output logic irq_enable,
   output logic [13:0] reset_vector,
   output logic [1:0] app_section_lock_field,
   output logic [1:0] boot_section_lock_field
);
   // ==========================================
   // Elaboration checks
   initial begin
      if (ADDR_W != 14) begin
         $error("ADDR_W must be 14");
      end
   end

   // ==========================================
   // Lock field storage
   wire logic prog_strobe;
   wire logic [1:0] prog_app;
   wire logic [1:0] prog_boot;
   assign prog_strobe = sw_lock_strobe | ext_lock_strobe;
   assign prog_app = (sw_lock_strobe ? sw_app_lock : 2'h3)
      & (ext_lock_strobe ? ext_app_lock : 2'h3);
   assign prog_boot = (sw_lock_strobe ? sw_boot_lock : 2'h3)
      & (ext_lock_strobe ? ext_boot_lock : 2'h3);

   lock_field_reg app_field (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .init_value(stored_app_lock),
      .init_load(lock_load),
      .prog_value(prog_app),
      .prog_strobe(prog_strobe),
      .erase(chip_erase),
      .field(app_section_lock_field)
   );

   lock_field_reg boot_field (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .init_value(stored_boot_lock),
      .init_load(lock_load),
      .prog_value(prog_boot),
      .prog_strobe(prog_strobe),
      .erase(chip_erase),
      .field(boot_section_lock_field)
   );

   // ==========================================
   // Field decode; one means unprogrammed
   wire logic app_hi;
   wire logic app_lo;
   wire logic boot_hi;
   wire logic boot_lo;
   assign app_hi = app_section_lock_field[`LOCK_HIGH_POS];
   assign app_lo = app_section_lock_field[`LOCK_LOW_POS];
   assign boot_hi = boot_section_lock_field[`LOCK_HIGH_POS];
   assign boot_lo = boot_section_lock_field[`LOCK_LOW_POS];

   wire logic app_store_block;
   wire logic app_load_block;
   wire logic boot_store_block;
   wire logic boot_load_block;
   assign app_store_block = ~app_lo;
   assign app_load_block = ~app_hi;
   assign boot_store_block = ~boot_lo;
   assign boot_load_block = ~boot_hi;

   // ==========================================
   // Section classification of the request
   state_type state;
   state_type next_state;
   access_type held;
   logic pc_in_boot;
   logic tgt_in_boot;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         held <= '0;
         pc_in_boot <= 1'b0;
         tgt_in_boot <= 1'b0;
      end else if (req_valid && req_ready) begin
         held <= req;
         pc_in_boot <= (req.pc >= BOOT_START);
         tgt_in_boot <= (req.target >= BOOT_START);
      end
   end

   // ==========================================
   // Verdict, general lock deliberately ignored
   wire logic is_store;
   wire logic is_load;
   wire logic deny_now;
   assign is_store = (held.op == OP_STORE);
   assign is_load = (held.op == OP_LOAD);
   // only section fields apply
   // Loads within the same section are never blocked
   assign deny_now =
      (is_store && !tgt_in_boot && app_store_block) ||
      (is_store && tgt_in_boot && boot_store_block) ||
      (is_load && !tgt_in_boot && pc_in_boot && app_load_block) ||
      (is_load && tgt_in_boot && !pc_in_boot && boot_load_block);

   // ==========================================
   // Request sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            next_state = ST_ANSWER;
         end
         ST_ANSWER: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   assign req_ready = (state == ST_IDLE);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         verdict <= '0;
         verdict_valid <= 1'b0;
      end else begin
         verdict_valid <= (state == ST_CHECK) && (held.op != OP_NONE);
         if (state == ST_CHECK) begin
            verdict.granted <= !deny_now && (held.op != OP_NONE);
            verdict.denied <= deny_now;
         end
      end
   end

   // ==========================================
   // Interrupt gating by execution section
   wire logic cur_in_boot;
   wire logic irq_block;
   assign cur_in_boot = (current_pc >= BOOT_START);
   assign irq_block =
      (vectors_in_boot && !cur_in_boot && app_load_block) ||
      (!vectors_in_boot && cur_in_boot && boot_load_block);
   // Registered so the gate is glitch free toward the core
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_enable <= 1'b0;
      end else begin
         irq_enable <= irq_enable_in && !irq_block;
      end
   end

   // ==========================================
   // Reset vector; fuse is a read-only input
   // boot-reset vector
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_vector <= `VEC_APP_BASE;
      end else begin
         reset_vector <= boot_reset_fuse_b ? `VEC_APP_BASE : BOOT_START;
      end
   end

   // ==========================================
   // Assertions
   property p_app_store;
      @(posedge sys_clk) disable iff (!rst_b)
      (state == ST_CHECK && is_store && !tgt_in_boot && !app_lo)
         |=> verdict_valid && verdict.denied;
   endproperty
   a_app_store: assert property (p_app_store)
      else $error("app store not denied");

   property p_app_open;
      @(posedge sys_clk) disable iff (!rst_b)
      (state == ST_CHECK && held.op != OP_NONE && !tgt_in_boot
         && app_section_lock_field == 2'h3) |=> verdict.granted;
   endproperty
   a_app_open: assert property (p_app_open)
      else $error("open app access refused");

   property p_app_load;
      @(posedge sys_clk) disable iff (!rst_b)
      (state == ST_CHECK && is_load && !tgt_in_boot && pc_in_boot
         && !app_hi) |=> verdict.denied;
   endproperty
   a_app_load: assert property (p_app_load)
      else $error("app load from boot not denied");

   property p_boot_store;
      @(posedge sys_clk) disable iff (!rst_b)
      (state == ST_CHECK && is_store && tgt_in_boot && boot_lo)
         |=> verdict.granted;
   endproperty
   a_boot_store: assert property (p_boot_store)
      else $error("boot store wrongly denied");

   property p_boot_load;
      @(posedge sys_clk) disable iff (!rst_b)
      (state == ST_CHECK && is_load && tgt_in_boot && !pc_in_boot
         && !boot_hi) |=> verdict.denied;
   endproperty
   a_boot_load: assert property (p_boot_load)
      else $error("boot load from app not denied");

   sequence s_accept;
      req_valid && req_ready;
   endsequence
   sequence s_answer;
      ##2 verdict_valid || (held.op == OP_NONE);
   endsequence
   property p_latency;
      @(posedge sys_clk) disable iff (!rst_b)
      s_accept |-> s_answer;
   endproperty
   a_latency: assert property (p_latency)
      else $error("verdict not two cycles after accept");

   property p_irq_gate;
      @(posedge sys_clk) disable iff (!rst_b)
      (vectors_in_boot && !cur_in_boot && !app_hi) |=> !irq_enable;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt not gated in app");

   property p_irq_boot;
      @(posedge sys_clk) disable iff (!rst_b)
      (!vectors_in_boot && cur_in_boot && !boot_hi) |=> !irq_enable;
   endproperty
   a_irq_boot: assert property (p_irq_boot)
      else $error("interrupt not gated in boot");

   property p_vector;
      @(posedge sys_clk) disable iff (!rst_b)
      !boot_reset_fuse_b |=> reset_vector == BOOT_START;
   endproperty
   a_vector: assert property (p_vector)
      else $error("reset vector not at boot start");

   property p_erase;
      @(posedge sys_clk) disable iff (!rst_b)
      chip_erase |=> app_section_lock_field == 2'h3
         && boot_section_lock_field == 2'h3;
   endproperty
   a_erase: assert property (p_erase)
      else $error("erase did not open locks");

   property p_no_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      (!chip_erase && !lock_load && !app_lo) |=> !app_lo;
   endproperty
   a_no_clear: assert property (p_no_clear)
      else $error("lock bit cleared without erase");
endmodule : section_lock_checker

// *** tb/core_model.sv ***
// Processor core model issuing flash load and store requests
module core_model
   import lock_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic req_ready,
   input wire verdict_type verdict,
   input wire logic verdict_valid,
   output access_type req,
   output logic req_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet bus at time zero
   initial begin
      req = '0;
      req_valid = 1'b0;
   end

   // One access: held until taken, then bus scrambled so stale data is gone
   task automatic issue(input access_type a, input int gap,
                        output verdict_type v, output logic seen);
      int n;
      v = '0;
      seen = 1'b0;
      n = 0;
      repeat (gap) @(negedge sys_clk);
      req = a;
      req_valid = 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 20);
      @(negedge sys_clk);
      req_valid = 1'b0;
      req = access_type'(~a);
      n = 0;
      // Answer pulse lasts one cycle, so look at every falling edge
      while (!seen && n < 6) begin
         if (verdict_valid === 1'b1) begin
            seen = 1'b1;
            v = verdict;
         end else begin
            @(negedge sys_clk);
            n++;
         end
      end
   endtask : issue
endmodule : core_model

// *** tb/section_lock_checker_bench.sv ***
// Self-checking bench for the flash section lock checker
`include "lock_cfg.svh"
module section_lock_checker_bench
   import lock_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [13:0] BOOT = `BOOT_START_DEFAULT;
   localparam int LIMIT = 20000;
   logic sys_clk = 1'b0;
   logic rst_b, req_valid, req_ready, verdict_valid, lock_load;
   logic sw_lock_strobe, ext_lock_strobe, chip_erase, boot_reset_fuse_b;
   logic vectors_in_boot, irq_enable_in, irq_enable, seen;
   logic [1:0] stored_app_lock, stored_boot_lock, sw_app_lock, sw_boot_lock;
   logic [1:0] ext_app_lock, ext_boot_lock, general_lock, app_f, boot_f;
   logic [13:0] current_pc, reset_vector;
   access_type req, a;
   verdict_type verdict, v;
   int seed = 91871;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;

   // ==========================================================
   // Clock, timeout and instances
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         print_verdict();
      end
   end
   section_lock_checker #(.ADDR_W(14), .BOOT_START(BOOT)) DUT (
      .sys_clk(sys_clk), .rst_b(rst_b), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .verdict(verdict),
      .verdict_valid(verdict_valid), .stored_app_lock(stored_app_lock),
      .stored_boot_lock(stored_boot_lock), .lock_load(lock_load),
      .sw_app_lock(sw_app_lock), .sw_boot_lock(sw_boot_lock),
      .sw_lock_strobe(sw_lock_strobe), .ext_lock_strobe(ext_lock_strobe),
      .ext_app_lock(ext_app_lock), .ext_boot_lock(ext_boot_lock),
      .chip_erase(chip_erase), .general_lock(general_lock),
      .boot_reset_fuse_b(boot_reset_fuse_b),
      .vectors_in_boot(vectors_in_boot), .current_pc(current_pc),
      .irq_enable_in(irq_enable_in), .irq_enable(irq_enable),
      .reset_vector(reset_vector), .app_section_lock_field(app_f),
      .boot_section_lock_field(boot_f));
   core_model core (.sys_clk(sys_clk), .rst_b(rst_b), .req_ready(req_ready),
      .verdict(verdict), .verdict_valid(verdict_valid), .req(req),
      .req_valid(req_valid));

   // ==========================================================
   // Expectations
   function automatic logic in_boot(input logic [13:0] ad);
      return ad >= BOOT;
   endfunction : in_boot
   function automatic logic exp_grant(input op_type op,
      input logic [13:0] pc, input logic [13:0] t, input logic [1:0] af,
      input logic [1:0] bf);
      logic [1:0] f;
      f = in_boot(t) ? bf : af;
      if (op == OP_STORE)
         return f[0];
      return (in_boot(pc) == in_boot(t)) || f[1];
   endfunction : exp_grant
   function automatic logic exp_irq(input logic en, input logic [13:0] pc,
      input logic vib, input logic [1:0] af, input logic [1:0] bf);
      if (!in_boot(pc) && vib && !af[1])
         return 1'b0;
      if (in_boot(pc) && !vib && !bf[1])
         return 1'b0;
      return en;
   endfunction : exp_irq
   // Random word address inside one section
   function automatic logic [13:0] pick(input logic boot_sec);
      int u;
      u = $random(seed) & 32'h7FFFFFFF;
      if (boot_sec)
         return 14'(int'(BOOT) + u % (16384 - int'(BOOT)));
      return 14'(u % int'(BOOT));
   endfunction : pick

   // ==========================================================
   // Compares, verdict and helpers
   task automatic cmp_bit(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_bit
   task automatic cmp_field(input string n, input logic [1:0] e,
                            input logic [1:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_field
   task automatic cmp_addr(input string n, input logic [13:0] e,
                           input logic [13:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_addr
   task automatic print_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   // Erase, then program by software; AND into 11 leaves the values
   task automatic set_fields(input logic [1:0] af, input logic [1:0] bf);
      @(negedge sys_clk) chip_erase = 1'b1;
      @(negedge sys_clk) chip_erase = 1'b0;
      {sw_app_lock, sw_boot_lock, sw_lock_strobe} = {af, bf, 1'b1};
      @(negedge sys_clk) sw_lock_strobe = 1'b0;
   endtask : set_fields
   task automatic reset_state();
      cmp_field("app field", 2'h3, app_f);
      cmp_field("boot field", 2'h3, boot_f);
      cmp_addr("reset vector", 14'h0000, reset_vector);
      cmp_bit("irq enable", 1'b0, irq_enable);
      cmp_field("verdict", 2'h0, verdict);
   endtask : reset_state

   // ==========================================================
   // Main sequence
   initial begin
      {rst_b, lock_load, sw_lock_strobe, ext_lock_strobe, chip_erase} = '0;
      {stored_app_lock, stored_boot_lock, sw_app_lock, sw_boot_lock} = '1;
      {ext_app_lock, ext_boot_lock, general_lock} = '1;
      {boot_reset_fuse_b, vectors_in_boot, irq_enable_in} = 3'h4;
      current_pc = 14'h0000;
      repeat (16) @(negedge sys_clk);
      reset_state();
      rst_b = 1'b1;
      $display("test reset done");
      // every field pair, op and section pair, back to back
      for (int m = 0; m < 16; m++) begin
         set_fields(2'(m >> 2), 2'(m));
         cmp_field("app field", 2'(m >> 2), app_f);
         for (int k = 0; k < 8; k++) begin
            a.op = k[0] ? OP_STORE : OP_LOAD;
            a.pc = pick(k[1]);
            a.target = pick(k[2]);
            general_lock = 2'($random(seed));
            core.issue(a, 0, v, seen);
            cmp_bit("answered", 1'b1, seen);
            cmp_bit("granted", exp_grant(a.op, a.pc, a.target, 2'(m >> 2),
               2'(m)), v.granted);
            cmp_bit("denied", !exp_grant(a.op, a.pc, a.target, 2'(m >> 2),
               2'(m)), v.denied);
         end
      end
      a.op = OP_NONE;
      core.issue(a, 2, v, seen);
      cmp_bit("answered", 1'b0, seen);
      $display("test access done");
      for (int f = 0; f < 4; f++) begin
         set_fields(2'(f), {f[0], f[1]});
         for (int j = 0; j < 8; j++) begin
            {vectors_in_boot, irq_enable_in} = {j[0], j[2] | f[0]};
            current_pc = pick(j[1]);
            @(negedge sys_clk);
            cmp_bit("irq enable", exp_irq(j[2] | f[0], current_pc, j[0],
               2'(f), {f[0], f[1]}), irq_enable);
         end
      end
      $display("test irq done");
      // programming only clears bits, erase wins over lock load
      set_fields(2'h2, 2'h3);
      {sw_app_lock, sw_boot_lock, sw_lock_strobe} = {2'h1, 2'h3, 1'b1};
      @(negedge sys_clk) sw_lock_strobe = 1'b0;
      cmp_field("app field", 2'h0, app_f);
      {ext_app_lock, ext_boot_lock, ext_lock_strobe} = {2'h3, 2'h2, 1'b1};
      @(negedge sys_clk) ext_lock_strobe = 1'b0;
      cmp_field("app field", 2'h0, app_f);
      cmp_field("boot field", 2'h2, boot_f);
      {stored_app_lock, stored_boot_lock, lock_load} = {2'h1, 2'h0, 1'b1};
      @(negedge sys_clk) lock_load = 1'b0;
      cmp_field("app field", 2'h1, app_f);
      cmp_field("boot field", 2'h0, boot_f);
      {chip_erase, lock_load, sw_app_lock, sw_lock_strobe} = 5'h18;
      @(negedge sys_clk) {chip_erase, lock_load, sw_lock_strobe} = '0;
      cmp_field("app field", 2'h3, app_f);
      cmp_field("boot field", 2'h3, boot_f);
      cmp_addr("reset vector", 14'h0000, reset_vector);
      $display("test fields done");
      // boot reset fuse steers the reset vector
      boot_reset_fuse_b = 1'b0;
      @(negedge sys_clk);
      cmp_addr("reset vector", BOOT, reset_vector);
      boot_reset_fuse_b = 1'b1;
      @(negedge sys_clk);
      cmp_addr("reset vector", 14'h0000, reset_vector);
      $display("test fuse done");
      set_fields(2'h0, 2'h0);
      rst_b = 1'b0;
      @(negedge sys_clk);
      reset_state();
      rst_b = 1'b1;
      $display("test second reset done");
      print_verdict();
   end
endmodule : section_lock_checker_bench
